/* File: rtl/fir_coeff_pkg.sv */
// How it works
// - 56 stored coefficients mirrored; the 6-bit tap read index reaches taps 0 to 63 of the 112.
// - data register is 24 bits: 23-bit coefficient plus control msb.
// - reset restores default coefficients; host must upload again.
// - only the third stage is programmable; sinc stages stay fixed.
// - third stage runs at twice output rate, decimation 16 to 512.
// - fixed length keeps group delay at 34 output periods; pad zeros.
// - third stage input rate follows power mode and decimation.
// - key 0xAC then 0x45 opens access; bit 0 reads key accepted.
// - control register: bit 7 access, bit 6 write, low bits index.
// - data write 0x800000 sets custom enable; sync keeps uploaded set.
// - sync pulse completes the upload; tapCoeff already carries each word once written.
// - completed upload with custom enable set flags ram crc failure unless disabled.
// - access on, write off: data register reads stored coefficient.
`default_nettype none
package fir_coeff_pkg;
  localparam logic [7:0] FILTER_CONFIG_ADDR = 8'h19;
  localparam logic [7:0] SYNC_RESET_ADDR = 8'h1D;
  localparam logic [7:0] DIAG_ENABLE_ADDR = 8'h2A;
  localparam logic [7:0] DIAG_STATUS_ADDR = 8'h30;
  localparam logic [7:0] COEFF_SELECT_CONTROL_ADDR = 8'h32;
  localparam logic [7:0] COEFF_VALUE_ADDR = 8'h33;
  localparam logic [7:0] UNLOCK_KEY_ADDR = 8'h34;
  localparam logic [7:0] KEY_FIRST = 8'hAC;
  localparam logic [7:0] KEY_SECOND = 8'h45;
  localparam logic [7:0] KEY_EXIT = 8'h55;
  localparam logic [7:0] FILTER_CONFIG_RESET = 8'h00;
  localparam logic [7:0] DIAG_ENABLE_RESET = 8'h0D;
  localparam int ACCESS_BIT = 7;
  localparam int WRITE_BIT = 6;
  localparam int RAM_CRC_BIT = 2;
  localparam int SYNC_START_BIT = 7;
  localparam int CUSTOM_BIT = 23;
  localparam int STORED_TAPS = 56;
  localparam int TOTAL_TAPS = 112;
  localparam int COEFF_WIDTH = 23;
  localparam int GROUP_DELAY_ODR = 34;
  localparam int DEC_MIN = 16;
  localparam int DEC_MAX = 512;
  localparam int MCLK_WAIT_PERIODS = 512;
  localparam logic [2:0] FILTER_USER = 3'h4;
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } key_state_type;
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [23:0] data;
  } reg_access_type;
endpackage : fir_coeff_pkg
`default_nettype wire

/* File: rtl/fir_tap_memory.sv */
`timescale 1ns/10ps
`default_nettype none
module fir_tap_memory
  import fir_coeff_pkg::*;
#(
  parameter int DEPTH = 56,
  parameter int WIDTH = 23
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic loadDefaults,
  input wire logic writeEn,
  input wire logic [5:0] writeIndex,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [5:0] readIndex,
  output logic [WIDTH-1:0] readData
);
  if (DEPTH > 64 || DEPTH < 1)
  begin : g_bad_depth
    $error("depth must fit a 6-bit index");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] readData_q;
  // default wideband set: arbitrary flat set summing to 2^22 over the top 32 words (24 to 55), zero below
  function automatic logic [WIDTH-1:0] defaultTap(input int i);
    defaultTap = (i >= 24) ? WIDTH'(23'h020000) : '0;
  endfunction : defaultTap
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= defaultTap(i);
      end
      readData_q <= '0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (loadDefaults)
        begin
          mem_q[i] <= defaultTap(i);
        end
        else if (writeEn && int'(writeIndex) == i)
        begin
          mem_q[i] <= writeData;
        end
      end
      readData_q <= (int'(readIndex) < DEPTH) ? mem_q[readIndex] : '0;
    end
  end
  assign readData = readData_q;
endmodule : fir_tap_memory
`default_nettype wire

/* File: rtl/fir_coefficient_upload.sv */
`timescale 1ns/10ps
`default_nettype none
module fir_coefficient_upload
  import fir_coeff_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [23:0] regWrData,
  input wire logic [5:0] tapReadIndex,
  output logic [23:0] regRdData,
  output logic [COEFF_WIDTH-1:0] tapCoeff,
  output logic [2:0] filterSelect,
  output logic customTapsActive,
  output logic syncPulse,
  output logic ramCrcError
);
  reg_access_type acc;
  key_state_type key_q, key_d;
  logic [7:0] control_q, control_d;
  logic [7:0] filterCfg_q, filterCfg_d;
  logic [7:0] diagEn_q, diagEn_d;
  logic custom_q, custom_d;
  logic uploaded_q, uploaded_d;
  logic crcErr_q, crcErr_d;
  logic sync_q, sync_d;
  logic [23:0] rd_q, rd_d;
  logic [5:0] tapIdx;
  logic memWrite, loadDefaults, keyOpen;
  logic [COEFF_WIDTH-1:0] memRead, shadowRead;
  logic [5:0] shadowIdx;

  // fixed mirrored length and decimation range; a stage of another length would shift the delay
  if (TOTAL_TAPS != 2 * STORED_TAPS || DEC_MAX % DEC_MIN != 0)
  begin : g_bad_stage
    $error("third stage length or rate range inconsistent");
  end

  assign acc = '{write: regWrite, read: regRead, addr: regAddr, data: regWrData};
  assign keyOpen = (key_q == KEY_OPEN);
  assign tapIdx = control_q[5:0];

  always_comb
  begin
    key_d = key_q;
    control_d = control_q;
    filterCfg_d = filterCfg_q;
    diagEn_d = diagEn_q;
    custom_d = custom_q;
    uploaded_d = uploaded_q;
    crcErr_d = crcErr_q;
    sync_d = 1'b0;
    memWrite = 1'b0;
    loadDefaults = 1'b0;
    if (acc.write)
    begin
      unique case (acc.addr)
        UNLOCK_KEY_ADDR:
        begin
          unique case (key_q)
            KEY_LOCKED: key_d = (acc.data[7:0] == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
            KEY_HALF: key_d = (acc.data[7:0] == KEY_SECOND) ? KEY_OPEN
                              : (acc.data[7:0] == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
            KEY_OPEN: key_d = (acc.data[7:0] == KEY_EXIT) ? KEY_LOCKED : KEY_OPEN;
            default: key_d = KEY_LOCKED;
          endcase
        end
        COEFF_SELECT_CONTROL_ADDR:
        begin
          if (keyOpen)
          begin
            control_d = acc.data[7:0];
          end
        end
        COEFF_VALUE_ADDR:
        begin
          if (keyOpen)
          begin
            if (control_q[ACCESS_BIT] && control_q[WRITE_BIT] && int'(tapIdx) < STORED_TAPS)
            begin
              memWrite = 1'b1;
              uploaded_d = 1'b1;
            end
            else if (!control_q[ACCESS_BIT] && acc.data[CUSTOM_BIT])
            begin
              custom_d = 1'b1;
            end
          end
        end
        FILTER_CONFIG_ADDR: filterCfg_d = acc.data[7:0];
        DIAG_ENABLE_ADDR: diagEn_d = acc.data[7:0];
        SYNC_RESET_ADDR: sync_d = 1'b1;
        default: ;
      endcase
    end
    if (sync_q)
    begin
      // sync without custom enable reloads the default wideband set
      loadDefaults = !custom_q;
      if (uploaded_q && custom_q && diagEn_q[RAM_CRC_BIT])
      begin
        crcErr_d = 1'b1;
      end
      uploaded_d = 1'b0;
    end
    if (!diagEn_q[RAM_CRC_BIT])
    begin
      crcErr_d = 1'b0;
    end
  end

  always_comb
  begin
    rd_d = 24'h000000;
    unique case (acc.addr)
      UNLOCK_KEY_ADDR: rd_d = {23'h0, keyOpen};
      COEFF_SELECT_CONTROL_ADDR: rd_d = {16'h0, control_q};
      COEFF_VALUE_ADDR:
        if (control_q[ACCESS_BIT] && !control_q[WRITE_BIT])
        begin
          rd_d = {custom_q, shadowRead};
        end
        else
        begin
          rd_d = {custom_q, 23'h0};
        end
      FILTER_CONFIG_ADDR: rd_d = {16'h0, filterCfg_q};
      DIAG_ENABLE_ADDR: rd_d = {16'h0, diagEn_q};
      DIAG_STATUS_ADDR: rd_d = {16'h0, 5'h0, crcErr_q, 2'h0};
      default: rd_d = 24'h000000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      key_q <= KEY_LOCKED;
      control_q <= 8'h00;
      filterCfg_q <= FILTER_CONFIG_RESET;
      diagEn_q <= DIAG_ENABLE_RESET;
      custom_q <= 1'b0;
      uploaded_q <= 1'b0;
      crcErr_q <= 1'b0;
      sync_q <= 1'b0;
      rd_q <= 24'h000000;
    end
    else
    begin
      key_q <= key_d;
      control_q <= control_d;
      filterCfg_q <= filterCfg_d;
      diagEn_q <= diagEn_d;
      custom_q <= custom_d;
      uploaded_q <= uploaded_d;
      crcErr_q <= crcErr_d;
      sync_q <= sync_d;
      rd_q <= acc.read ? rd_d : rd_q;
    end
  end

  // mirror: tap k and tap 111-k share stored word min(k,111-k)
  function automatic logic [5:0] mirrorIndex(input logic [6:0] tap);
    mirrorIndex = (int'(tap) < STORED_TAPS) ? tap[5:0]
                  : 6'(TOTAL_TAPS - 1 - int'(tap));
  endfunction : mirrorIndex

  // readback mode owns the read port, so the selected word is ready before the read strobe
  assign shadowIdx = (control_q[ACCESS_BIT] && !control_q[WRITE_BIT]) ? tapIdx
                     : mirrorIndex({1'b0, tapReadIndex});

  fir_tap_memory #(.DEPTH(STORED_TAPS), .WIDTH(COEFF_WIDTH)) tapMem (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .loadDefaults(loadDefaults),
    .writeEn(memWrite),
    .writeIndex(tapIdx),
    .writeData(regWrData[COEFF_WIDTH-1:0]),
    .readIndex(shadowIdx),
    .readData(memRead)
  );
  assign shadowRead = memRead;

  assign regRdData = rd_q;
  assign tapCoeff = memRead;
  assign filterSelect = filterCfg_q[6:4];
  assign customTapsActive = custom_q;
  assign syncPulse = sync_q;
  assign ramCrcError = crcErr_q;

  chk_key_locks_writes: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regWrite && regAddr == COEFF_SELECT_CONTROL_ADDR && key_q != KEY_OPEN) |=> $stable(control_q))
    else $error("control changed without key");
  chk_key_sequence: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regWrite && regAddr == UNLOCK_KEY_ADDR && key_q == KEY_HALF && regWrData[7:0] == KEY_SECOND)
    |=> key_q == KEY_OPEN)
    else $error("key pair not accepted");
  chk_custom_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regWrite && regAddr == COEFF_VALUE_ADDR && key_q == KEY_OPEN && !control_q[ACCESS_BIT]
     && regWrData[CUSTOM_BIT]) |=> customTapsActive)
    else $error("custom enable not set");
  chk_sync_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regWrite && regAddr == SYNC_RESET_ADDR) |=> syncPulse)
    else $error("sync pulse missing");
  chk_sync_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (syncPulse && !(regWrite && regAddr == SYNC_RESET_ADDR)) |=> !syncPulse)
    else $error("sync pulse too long");
  chk_crc_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sync_q && uploaded_q && custom_q && diagEn_q[RAM_CRC_BIT]) |=> ramCrcError)
    else $error("crc flag not raised");
  chk_ctrl_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regWrite && regAddr == COEFF_SELECT_CONTROL_ADDR && key_q == KEY_OPEN)
    |=> control_q == $past(regWrData[7:0]))
    else $error("control not stored");
  chk_readback: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regRead && regAddr == COEFF_VALUE_ADDR && control_q[ACCESS_BIT] && !control_q[WRITE_BIT])
    |=> regRdData[COEFF_WIDTH-1:0] == shadowRead)
    else $error("readback mismatch");
  chk_select_field: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regWrite && regAddr == FILTER_CONFIG_ADDR) |=> filterSelect == $past(regWrData[6:4]))
    else $error("filter select field wrong");
endmodule : fir_coefficient_upload
`default_nettype wire

/* File: verif/host_port_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_port_model #(
  parameter int GAP = 8
)
(
  input wire logic clk_sys,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [23:0] regWrData
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'hFF;
    regWrData = 24'hFFFFFF;
  end
  // one strobed access; afterwards the bus shows inverted junk, never the old value
  task automatic access(input logic wr, input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    #1;
    regWrite = wr;
    regRead = !wr;
    regAddr = a;
    regWrData = d;
    @(posedge clk_sys);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    // shortened stand-in for the master-clock settle wait
    repeat (GAP) @(posedge clk_sys);
    #1;
  endtask : access
endmodule : host_port_model
`default_nettype wire

/* File: verif/test_fir_coefficient_upload.sv */
`timescale 1ns/10ps
`default_nettype none
module test_fir_coefficient_upload;
  import fir_coeff_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic regWrite, regRead, rdPend = 1'b0;
  logic [7:0] regAddr;
  logic [23:0] regWrData, regRdData;
  logic [5:0] tapReadIndex = 6'h00;
  logic [COEFF_WIDTH-1:0] tapCoeff;
  logic [2:0] filterSelect;
  logic customTapsActive, syncPulse, ramCrcError;
  logic [22:0] taps [STORED_TAPS];
  logic [23:0] expQ [$];
  logic [31:0] lfsr = 32'h0BB2E58F;
  logic [22:0] tapSum = 23'h000000;
  int fails = 0;
  int nChecks = 0;
  int cycles = 0;
  int syncCount = 0;
  always #2.5 clk_sys = ~clk_sys;
  host_port_model #(.GAP(8)) host_port_model_i (.clk_sys(clk_sys), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData));
  fir_coefficient_upload fir_coefficient_upload_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .tapReadIndex(tapReadIndex), .regRdData(regRdData), .tapCoeff(tapCoeff),
    .filterSelect(filterSelect), .customTapsActive(customTapsActive),
    .syncPulse(syncPulse), .ramCrcError(ramCrcError));
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand
  task automatic check(input string what, input logic [23:0] e, input logic [23:0] got);
    nChecks++;
    if (got !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask : check
  task automatic test_done;
    if (fails == 0 && nChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    host_port_model_i.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    expQ.push_back(e);
    host_port_model_i.access(1'b0, a, 24'h0);
  endtask : rd
  task automatic tap(input int i, input logic [22:0] e);
    tapReadIndex = 6'(i);
    repeat (2) @(posedge clk_sys);
    #1;
    check("tapCoeff", {1'b0, e}, {1'b0, tapCoeff});
  endtask : tap
  // read results land one cycle after the strobe edge
  always @(posedge clk_sys)
  begin
    if (rdPend)
      check("regRdData", expQ.pop_front(), regRdData);
    rdPend <= regRead;
    if (syncPulse === 1'b1)
      syncCount++;
    cycles++;
    if (cycles == 10000)
    begin
      fails++;
      test_done();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    rd(UNLOCK_KEY_ADDR, 24'h0);
    wr(COEFF_SELECT_CONTROL_ADDR, 24'hC0);
    wr(COEFF_VALUE_ADDR, 24'h00ABCD);
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_FIRST});
    wr(UNLOCK_KEY_ADDR, 24'h12);
    rd(UNLOCK_KEY_ADDR, 24'h0);
    wr(FILTER_CONFIG_ADDR, {17'h0, FILTER_USER, 4'h0});
    check("filterSelect", 24'(FILTER_USER), 24'(filterSelect));
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_FIRST});
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_SECOND});
    rd(UNLOCK_KEY_ADDR, 24'h1);
    wr(COEFF_SELECT_CONTROL_ADDR, 24'h80);
    rd(COEFF_VALUE_ADDR, 24'h0);
    wr(COEFF_SELECT_CONTROL_ADDR, 24'h9E);
    rd(COEFF_VALUE_ADDR, 24'h020000);
    for (int i = 0; i < STORED_TAPS; i++)
    begin
      lfsr = nextRand(lfsr);
      // outer taps padded with zeros; the last word trims the set to the 2^22 sum
      taps[i] = (i < 4) ? 23'h000000 : lfsr[22:0];
      if (i == STORED_TAPS - 1)
        taps[i] = 23'h400000 - tapSum;
      tapSum = tapSum + taps[i];
      wr(COEFF_SELECT_CONTROL_ADDR, 24'(8'hC0 | 8'(i)));
      wr(COEFF_VALUE_ADDR, {1'b0, taps[i]});
    end
    // index 56 is out of range and must not alias onto index 0
    wr(COEFF_SELECT_CONTROL_ADDR, 24'hF8);
    wr(COEFF_VALUE_ADDR, 24'h7FFFFF);
    wr(COEFF_SELECT_CONTROL_ADDR, 24'h80);
    for (int i = 0; i < STORED_TAPS; i++)
    begin
      wr(COEFF_SELECT_CONTROL_ADDR, 24'(8'h80 | 8'(i)));
      rd(COEFF_VALUE_ADDR, {1'b0, taps[i]});
      tap(i, taps[i]);
    end
    wr(COEFF_SELECT_CONTROL_ADDR, 24'h0);
    wr(COEFF_VALUE_ADDR, 24'h800000);
    check("customTapsActive", 24'h1, 24'(customTapsActive));
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_EXIT});
    rd(UNLOCK_KEY_ADDR, 24'h0);
    wr(SYNC_RESET_ADDR, 24'h80);
    check("syncPulse", 24'h1, 24'(syncCount));
    check("ramCrcError", 24'h1, 24'(ramCrcError));
    rd(DIAG_STATUS_ADDR, 24'h04);
    tap(5, taps[5]);
    tap(60, taps[51]);
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    check("customTapsActive", 24'h0, 24'(customTapsActive));
    check("ramCrcError", 24'h0, 24'(ramCrcError));
    tap(30, 23'h020000);
    wr(DIAG_ENABLE_ADDR, 24'h09);
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_FIRST});
    wr(UNLOCK_KEY_ADDR, {16'h0, KEY_SECOND});
    wr(COEFF_SELECT_CONTROL_ADDR, 24'hC5);
    wr(COEFF_VALUE_ADDR, 24'h000123);
    wr(COEFF_SELECT_CONTROL_ADDR, 24'h00);
    // no custom enable yet: sync must reload the default set
    wr(SYNC_RESET_ADDR, 24'h80);
    tap(5, 23'h000000);
    wr(COEFF_SELECT_CONTROL_ADDR, 24'hC5);
    wr(COEFF_VALUE_ADDR, 24'h000123);
    wr(COEFF_SELECT_CONTROL_ADDR, 24'h00);
    wr(COEFF_VALUE_ADDR, 24'h800000);
    wr(SYNC_RESET_ADDR, 24'h80);
    check("ramCrcError", 24'h0, 24'(ramCrcError));
    tap(5, 23'h000123);
    check("customTapsActive", 24'h1, 24'(customTapsActive));
    test_done();
  end
endmodule : test_fir_coefficient_upload
`default_nettype wire
